// ### rtl/smp_pkg.sv
/*
  Shared constants, types and the phase lookup function for the serial
  microstep position block.
  Assumes a single clock domain; the serial link is sampled by that clock.
*/
package smp_pkg;

  // ==========================================================================
  // Command word layout
  // ==========================================================================
  localparam int unsigned SMP_WORD_W        = 16;
  localparam int unsigned SMP_ADDR_LSB      = 13;
  localparam int unsigned SMP_ADDR_W        = 3;
  localparam logic [2:0]  SMP_ADDR_RUN      = 3'h6;
  localparam logic [2:0]  SMP_ADDR_TABLE    = 3'h5;
  localparam int unsigned SMP_SC_W          = 6;
  localparam int unsigned SMP_CFG_LSB       = 6;
  localparam int unsigned SMP_CFG_W         = 7;
  localparam int unsigned SMP_RESTART_BIT   = 12;
  localparam logic [4:0]  SMP_BIT_COUNT     = 5'h10;

  // ==========================================================================
  // Step angle and phase table
  // ==========================================================================
  localparam int unsigned SMP_ANGLE_W       = 6;
  localparam int unsigned SMP_LEVEL_W       = 6;
  localparam int unsigned SMP_TABLE_N       = 16;
  localparam logic [5:0]  SMP_ANGLE_RESET   = 6'h00;
  localparam logic [5:0]  SMP_PHASE_SHIFT   = 6'h10;
  localparam logic [6:0]  SMP_CFG_RESET     = 7'h00;

  typedef logic [SMP_TABLE_N-1:0][SMP_LEVEL_W-1:0] smp_table_type;

  // Default quarter sinusoid, entry 0 rightmost.
  localparam smp_table_type SMP_PT_DEFAULT = {
    6'h3F, 6'h3F, 6'h3E, 6'h3C, 6'h3A, 6'h37, 6'h34, 6'h30,
    6'h2C, 6'h28, 6'h23, 6'h1D, 6'h17, 6'h12, 6'h0B, 6'h05};

  // Returns {reverse, level} of phase A at the given step angle.
  function automatic logic [6:0] smp_phase_lookup(input logic [5:0] angle, input smp_table_type tbl);
    logic [3:0] idx;
    logic [5:0] lvl;
    idx = angle[3:0];
    if (angle[4]) begin
      lvl = tbl[4'hF - idx];
    end else if (idx == 4'h0) begin
      lvl = 6'h00;
    end else begin
      lvl = tbl[idx - 4'h1];
    end
    return {angle[5], lvl};
  endfunction

endpackage

// ### rtl/smp_word_if.sv
/*
  Carrier for a received command word from the serial receiver to the core.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface smp_word_if;
  logic [15:0] word;
  logic        word_valid;
  modport rx   (output word, output word_valid);
  modport core (input word, input word_valid);
endinterface

// ### rtl/smp_serial_rx.sv
/*
  Serial receiver: synchronises clock, data and strobe pins, shifts data on
  clock rising edges while the strobe is low, and offers the word on the
  strobe rising edge only if exactly 16 bits were shifted in.
  Assumes the link clock is much slower than clk.
*/
`timescale 1ns/10ps
module smp_serial_rx
  import smp_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Serial pins
  input  wire logic serial_clock,
  input  wire logic serial_data_in,
  input  wire logic serial_strobe_n,
  // Word to core
  smp_word_if.rx    link
);

  typedef struct packed {
    logic [2:0]  sck;
    logic [1:0]  sdi;
    logic [2:0]  stb;
    logic [15:0] shift;
    logic [4:0]  count;
    logic [15:0] word;
    logic        valid;
  } smp_rx_state_type;

  smp_rx_state_type state_q;
  smp_rx_state_type state_d;

  always_comb begin
    state_d       = state_q;
    state_d.sck   = {state_q.sck[1:0], serial_clock};
    state_d.sdi   = {state_q.sdi[0], serial_data_in};
    state_d.stb   = {state_q.stb[1:0], serial_strobe_n};
    state_d.valid = 1'b0;
    // Frame start clears the bit count.
    if (state_q.stb[2] && !state_q.stb[1]) begin
      state_d.count = 5'h00;
    end else if (!state_q.stb[1] && state_q.sck[1] && !state_q.sck[2]) begin
      state_d.shift = {state_q.shift[14:0], state_q.sdi[1]};
      if (state_q.count != 5'h1F) begin
        state_d.count = state_q.count + 5'h01;
      end
    end
    // RULE8 RULE9: only strobe rise steps
    if (!state_q.stb[2] && state_q.stb[1] && state_q.count == SMP_BIT_COUNT) begin
      state_d.word  = state_q.shift;
      state_d.valid = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '{sck: 3'h0, sdi: 2'h0, stb: 3'h7, shift: 16'h0000, count: 5'h00,
                   word: 16'h0000, valid: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign link.word       = state_q.word;
  assign link.word_valid = state_q.valid;

endmodule

// ### rtl/smp_position_core.sv
/*
  Serial microstep position control: keeps the step angle number, applies
  step changes from run words, holds the loadable phase current table and
  drives the two phase levels and directions.
  Assumes a host on the four-wire serial link; no other control input.
*/
// Operation
// RULE1: All motion features reachable through serial link.
// RULE2: Step angle wraps modulo 64.
// RULE3: Low six run bits signed step change.
// RULE4: Plus one forward, minus one reverse microstep.
// RULE5: Host uses 16, 8, 4, 2 magnitudes.
// RULE6: Host repeats 000100 or 111100 for quarter.
// RULE7: Host sends full run word each time.
// RULE8: Step applied only on strobe rising edge.
// RULE9: Step rate follows strobe, not serial clock.
// RULE10: Phase table reloadable over serial link.
// RULE11: Unloaded table keeps default sinusoid.
// RULE12: Resolution selects ignored for serial motion.
// RULE13: Phase level is six-bit table value.
// RULE14: Exactly one step per completed run write.
`timescale 1ns/10ps
module smp_position_core
  import smp_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Serial pins
  input  wire logic                   serial_clock,
  input  wire logic                   serial_data_in,
  input  wire logic                   serial_strobe_n,
  // Position and phase drive
  output logic [smp_pkg::SMP_ANGLE_W-1:0] step_angle,
  output logic [smp_pkg::SMP_LEVEL_W-1:0] phase_a_level,
  output logic                            phase_a_reverse,
  output logic [smp_pkg::SMP_LEVEL_W-1:0] phase_b_level,
  output logic                            phase_b_reverse,
  // Configuration and status
  output logic [smp_pkg::SMP_CFG_W-1:0]   run_config,
  output logic                            profile_loaded
);
  import smp_pkg::*;

  typedef struct packed {
    logic [5:0]    step;
    smp_table_type table_v;
    logic [3:0]    load_ptr;
    logic          loaded;
    logic [6:0]    cfg;
    logic [5:0]    a_level;
    logic          a_rev;
    logic [5:0]    b_level;
    logic          b_rev;
  } smp_core_state_type;

  smp_core_state_type state_q;
  smp_core_state_type state_d;
  smp_word_if         link ();

  smp_serial_rx u_rx (
    .clk             (clk),
    .rst_n           (rst_n),
    .serial_clock    (serial_clock),
    .serial_data_in  (serial_data_in),
    .serial_strobe_n (serial_strobe_n),
    .link            (link)
  );

  logic       run_write;
  logic       table_write;
  logic [6:0] a_look;
  logic [6:0] b_look;
  logic [5:0] next_step;

  // RULE1: decode by address
  assign run_write   = link.word_valid && link.word[15:13] == SMP_ADDR_RUN;
  assign table_write = link.word_valid && link.word[15:13] == SMP_ADDR_TABLE;
  // RULE2: six-bit sum wraps
  // RULE4: sign sets direction
  // RULE12: no resolution scaling
  assign next_step   = 6'(state_q.step + link.word[SMP_SC_W-1:0]);
  assign a_look      = smp_phase_lookup(state_q.step, state_q.table_v);
  assign b_look      = smp_phase_lookup(6'(state_q.step + SMP_PHASE_SHIFT), state_q.table_v);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    // RULE3: signed step change
    // RULE14: one step per write
    if (run_write) begin
      state_d.step = next_step;
      state_d.cfg  = link.word[SMP_CFG_LSB +: SMP_CFG_W];
    end
    // RULE10: sequential table load
    if (table_write) begin
      if (link.word[SMP_RESTART_BIT]) begin
        state_d.table_v[0] = link.word[SMP_LEVEL_W-1:0];
        state_d.load_ptr   = 4'h1;
      end else begin
        state_d.table_v[state_q.load_ptr] = link.word[SMP_LEVEL_W-1:0];
        state_d.load_ptr                  = state_q.load_ptr + 4'h1;
      end
      state_d.loaded = 1'b1;
    end
    // RULE13: table drives phase levels
    state_d.a_level = a_look[5:0];
    state_d.a_rev   = a_look[6];
    state_d.b_level = b_look[5:0];
    state_d.b_rev   = b_look[6];
  end

  // RULE11: default profile at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '{step: SMP_ANGLE_RESET, table_v: SMP_PT_DEFAULT, load_ptr: 4'h0, loaded: 1'b0,
                   cfg: SMP_CFG_RESET, a_level: 6'h00, a_rev: 1'b0, b_level: 6'h3F, b_rev: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign step_angle      = state_q.step;
  assign phase_a_level   = state_q.a_level;
  assign phase_a_reverse = state_q.a_rev;
  assign phase_b_level   = state_q.b_level;
  assign phase_b_reverse = state_q.b_rev;
  assign run_config      = state_q.cfg;
  assign profile_loaded  = state_q.loaded;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_step_add;
    run_write |=> step_angle == 6'($past(step_angle) + $past(link.word[SMP_SC_W-1:0]));
  endproperty
  a_step_add: assert property (p_step_add) else $error("Step angle did not take the step change."); // RULE3

  property p_wrap_up;
    run_write && step_angle == 6'h3F && link.word[5:0] == 6'h01 |=> step_angle == 6'h00;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("Step angle did not wrap from 63 to 0."); // RULE2

  property p_forward;
    run_write && !link.word[5] && link.word[5:0] != 6'h00 |=> step_angle != $past(step_angle);
  endproperty
  a_forward: assert property (p_forward) else $error("Forward step left angle unchanged."); // RULE4

  property p_hold;
    !run_write |=> $stable(step_angle);
  endproperty
  a_hold: assert property (p_hold) else $error("Step angle moved without a run write."); // RULE14

  property p_strobe_only;
    serial_strobe_n && $past(serial_strobe_n) ##1 serial_strobe_n [*4] |-> $stable(step_angle);
  endproperty
  a_strobe_only: assert property (p_strobe_only) else $error("Step angle moved while strobe stayed high."); // RULE9

  property p_default_table;
    !profile_loaded |-> state_q.table_v == SMP_PT_DEFAULT;
  endproperty
  a_default_table: assert property (p_default_table) else $error("Table changed without a load."); // RULE11

  property p_table_load;
    table_write && !link.word[SMP_RESTART_BIT] |=> state_q.table_v[$past(state_q.load_ptr)] == $past(link.word[5:0])
      && profile_loaded;
  endproperty
  a_table_load: assert property (p_table_load) else $error("Table entry not written."); // RULE10

  property p_zero_point;
    step_angle == 6'h00 && $stable(step_angle) |=> phase_a_level == 6'h00
      && phase_b_level == $past(state_q.table_v[15]);
  endproperty
  a_zero_point: assert property (p_zero_point) else $error("Phase levels wrong at angle zero."); // RULE13

  property p_config;
    run_write |=> run_config == $past(link.word[12:6]);
  endproperty
  a_config: assert property (p_config) else $error("Run configuration not captured."); // RULE1

  property p_wrap_down;
    run_write && step_angle == 6'h00 && link.word[5:0] == 6'h3E |=> step_angle == 6'h3E;
  endproperty
  a_wrap_down: assert property (p_wrap_down) else $error("Step angle did not wrap from 0 to 62."); // RULE2

  property p_reverse;
    run_write && link.word[5] |=> step_angle != $past(step_angle);
  endproperty
  a_reverse: assert property (p_reverse) else $error("Reverse step left angle unchanged."); // RULE4

  property p_direction;
    phase_a_reverse == $past(step_angle[5]) && phase_b_reverse == ($past(step_angle[5]) ^ $past(step_angle[4]));
  endproperty
  a_direction: assert property (p_direction) else $error("Phase direction does not follow the quadrant."); // RULE13

  property p_level_hold;
    $stable(step_angle) && $stable(state_q.table_v) |=> $stable(phase_a_level) && $stable(phase_b_level);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("Phase level moved with angle and table steady."); // RULE13

  property p_quarter_point;
    step_angle == 6'h10 && $stable(step_angle) |=> phase_b_level == 6'h00
      && phase_a_level == $past(state_q.table_v[15]);
  endproperty
  a_quarter_point: assert property (p_quarter_point) else $error("Phase levels wrong at angle sixteen."); // RULE13

  property p_restart;
    table_write && link.word[SMP_RESTART_BIT] |=> state_q.table_v[0] == $past(link.word[5:0])
      && state_q.load_ptr == 4'h1;
  endproperty
  a_restart: assert property (p_restart) else $error("Restart load did not write entry zero."); // RULE10

  property p_single;
    link.word_valid |=> !link.word_valid;
  endproperty
  a_single: assert property (p_single) else $error("Word offered on two cycles in a row."); // RULE14

  property p_refused;
    link.word_valid && link.word[15:13] != SMP_ADDR_RUN && link.word[15:13] != SMP_ADDR_TABLE
      |=> $stable(step_angle) && $stable(run_config) && $stable(profile_loaded);
  endproperty
  a_refused: assert property (p_refused) else $error("Unknown word changed the position state."); // RULE14

  c_quarter_fwd: cover property (run_write && link.word[5:0] == 6'h04);
  c_quarter_rev: cover property (run_write && link.word[5:0] == 6'h3C);
  c_wrap:        cover property (run_write && step_angle == 6'h3F && !link.word[5]);
  c_load:        cover property (table_write);

endmodule

// ### testbench/smp_host_model.sv
/*
  Host model for the four-wire serial link: shifts words MSB first and raises the strobe on request.
  Assumes the bench clock clk; every pin changes at its falling edge, link clock period 80 ns.
*/
`timescale 1ns/10ps
module smp_host_model (
  // Clock
  input  wire logic clk,
  // Serial pins
  output logic      serial_clock,
  output logic      serial_data_in,
  output logic      serial_strobe_n
);
  initial begin
    serial_clock    = 1'b0;
    serial_data_in  = 1'b0;
    serial_strobe_n = 1'b1;
  end

  // ==========================================================================
  // Frame tasks
  // ==========================================================================
  // first nbits bits of the word sent MSB first, link clock still outside frames.
  task automatic shift(input logic [15:0] word, input int nbits);
    @(negedge clk);
    serial_strobe_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      repeat (10) @(negedge clk);
      serial_data_in = word[15-i];
      serial_clock   = 1'b0;
      repeat (10) @(negedge clk);
      serial_clock = 1'b1;
    end
    repeat (10) @(negedge clk);
    serial_clock   = 1'b0;
    serial_data_in = ~serial_data_in;
  endtask

  // the strobe rise alone sets the step moment.
  task automatic strobe_up();
    @(negedge clk);
    serial_strobe_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
endmodule

// ### testbench/test_serial_microstep_position_control.sv
/*
  Self-checking bench: a host model sends run and table words, a model in integers predicts every output.
  Assumes the position core as top and the host model beside it.
*/
`timescale 1ns/10ps
module test_serial_microstep_position_control;
  import smp_pkg::*;
  logic       clk;
  logic       rst_n;
  logic       sck;
  logic       sdi;
  logic       stb_n;
  logic [5:0] step_angle;
  logic [5:0] pa_lvl;
  logic       pa_rev;
  logic [5:0] pb_lvl;
  logic       pb_rev;
  logic [6:0] cfg;
  logic       loaded;
  int         miscompares;
  int         check_count;
  int         seed;
  int         ang;
  int         ecfg;
  int         eload;
  int         ptr;
  int         pt[16];

  smp_host_model i_smp_host_model (.clk(clk), .serial_clock(sck), .serial_data_in(sdi), .serial_strobe_n(stb_n));
  smp_position_core i_smp_position_core (.clk(clk), .rst_n(rst_n), .serial_clock(sck), .serial_data_in(sdi),
    .serial_strobe_n(stb_n), .step_angle(step_angle), .phase_a_level(pa_lvl), .phase_a_reverse(pa_rev),
    .phase_b_level(pb_lvl), .phase_b_reverse(pb_rev), .run_config(cfg), .profile_loaded(loaded));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string name, input int exp, input logic [7:0] got);
    check_count++;
    if (got !== exp[7:0]) begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  function automatic int lvl(input int s);
    int i;
    i = s % 16;
    if ((s / 16) % 2 == 1) return pt[15-i];
    if (i == 0) return 0;
    return pt[i-1];
  endfunction

  task automatic check_all();
    int b;
    b = (ang + 16) % 64;
    check("step_angle", ang, step_angle);
    check("phase_a_level", lvl(ang), pa_lvl);
    check("phase_a_reverse", ang / 32, pa_rev);
    check("phase_b_level", lvl(b), pb_lvl);
    check("phase_b_reverse", b / 32, pb_rev);
    check("run_config", ecfg, cfg);
    check("profile_loaded", eload, loaded);
  endtask

  // ==========================================================================
  // One frame, then prediction and comparison
  // ==========================================================================
  task automatic send(input logic [2:0] addr, input logic [6:0] c, input logic [5:0] v, input int nbits);
    i_smp_host_model.shift({addr, c, v}, nbits);
    repeat (8) @(negedge clk);
    check("angle_before_strobe", ang, step_angle);
    i_smp_host_model.strobe_up();
    if (nbits == 16 && addr == SMP_ADDR_RUN) begin
      ang  = (ang + int'($signed(v)) + 64) % 64;
      ecfg = c;
    end
    if (nbits == 16 && addr == SMP_ADDR_TABLE) begin
      if (c[6]) ptr = 0;
      pt[ptr] = v;
      ptr     = (ptr + 1) % 16;
      eload   = 1;
    end
    repeat (6) @(negedge clk);
    check_all();
    repeat (20 + ($random(seed) & 31)) @(negedge clk);
    check_all();
  endtask

  task automatic step(input int d);
    send(SMP_ADDR_RUN, 7'($random(seed)), 6'(d), 16);
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    int steps[10] = '{16, 8, 4, 2, -16, -8, -4, -2, 31, -32};
    int dflt[16]  = '{5, 11, 18, 23, 29, 35, 40, 44, 48, 52, 55, 58, 60, 62, 63, 63};
    seed        = 32'hfa64_c937;
    miscompares = 0;
    check_count = 0;
    ang         = 0;
    ecfg        = 0;
    eload       = 0;
    ptr         = 0;
    pt          = dflt;
    rst_n       = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check_all();
    foreach (steps[i]) step(steps[i]);
    repeat (3) step(4);
    repeat (3) step(-4);
    step(((63 - ang + 32) % 64) - 32);
    step(1);
    step(-2);
    send(SMP_ADDR_RUN, 7'h55, 6'h04, 15);
    send(3'h3, 7'h2a, 6'h04, 16);
    send(SMP_ADDR_TABLE, 7'h40, 6'h09, 16);
    for (int i = 0; i < 15; i++) send(SMP_ADDR_TABLE, 7'h00, 6'($random(seed)), 16);
    repeat (20) step($random(seed) % 32);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    ang   = 0;
    ecfg  = 0;
    eload = 0;
    ptr   = 0;
    pt    = dflt;
    repeat (4) @(negedge clk);
    check_all();
    repeat (4) step($random(seed) % 32);
    report_and_stop();
  end
endmodule
